//--- src/crc_calc_pkg.sv
`default_nettype none
package crc_calc_pkg;

  // byte addresses of the word registers on the bus
  localparam logic [3:0] OFS_DATA    = 4'h0;
  localparam logic [3:0] OFS_SEED    = 4'h4;
  localparam logic [3:0] OFS_CONTROL = 4'h8;
  localparam logic [3:0] OFS_GEN     = 4'hC;

  // checksum_control field positions
  localparam int CTL_RESET_BIT   = 0;
  localparam int CTL_WSEL_LO     = 3;
  localparam int CTL_RIN_LO      = 5;
  localparam int CTL_ROUT_BIT    = 7;

  // reset values
  localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_SEED    = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_GEN     = 32'h04C1_1DB7;
  localparam logic [31:0] ALL_ONES    = 32'hFFFF_FFFF;

  // divisor width select codes
  localparam logic [1:0] WSEL_32 = 2'h0;
  localparam logic [1:0] WSEL_16 = 2'h1;
  localparam logic [1:0] WSEL_8  = 2'h2;
  localparam logic [1:0] WSEL_7  = 2'h3;

  // input reversal modes
  localparam logic [1:0] RIN_NONE = 2'h0;
  localparam logic [1:0] RIN_BYTE = 2'h1;
  localparam logic [1:0] RIN_HALF = 2'h2;
  localparam logic [1:0] RIN_WORD = 2'h3;

  // written data size codes, carried beside each queued word
  localparam logic [1:0] DSZ_32 = 2'h0;
  localparam logic [1:0] DSZ_16 = 2'h1;
  localparam logic [1:0] DSZ_8  = 2'h2;

  // byte enable patterns that mark narrow writes
  localparam logic [3:0] BE_BYTE = 4'h1;
  localparam logic [3:0] BE_HALF = 4'h3;

  localparam int FIFO_DEPTH_DEF = 4;
  localparam int FIFO_WIDTH     = 34;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } eng_state_t;

endpackage
`default_nettype wire

//--- src/crc_calc_unit.sv
`default_nettype none

module crc_fifo #(
  parameter int WIDTH = crc_calc_pkg::FIFO_WIDTH,
  parameter int DEPTH = crc_calc_pkg::FIFO_DEPTH_DEF
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("crc_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t s_r;
  fifo_state_t s_nxt;
  logic        push;
  logic        pop;

  assign in_ready  = (s_r.count != (AW+1)'(DEPTH));
  assign out_valid = (s_r.count != '0);
  assign out_data  = s_r.mem[s_r.rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wptr] = in_data;
      s_nxt.wptr          = s_r.wptr + 1'b1;
    end
    if (pop) begin
      s_nxt.rptr = s_r.rptr + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.count = s_r.count + 1'b1;
    end else if (pop && !push) begin
      s_nxt.count = s_r.count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

module crc_calc_unit #(
  parameter int FIFO_DEPTH = crc_calc_pkg::FIFO_DEPTH_DEF
) (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESET,
  // avalon-mm slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST
);
  localparam int FW = crc_calc_pkg::FIFO_WIDTH;

  generate
    if (FW != 2 + 32) begin : g_bad_width
      $error("queue word must hold the size code and one data word");
    end
  endgenerate

  typedef struct packed {
    logic [31:0]                 checksum_data;
    logic [31:0]                 checksum_seed;
    logic [31:0]                 generator_coefficients;
    logic [1:0]                  divisor_width_sel;
    logic [1:0]                  input_bit_reverse;
    logic                        output_bit_reverse;
    crc_calc_pkg::eng_state_t    state;
    logic [5:0]                  steps;
    logic [31:0]                 work;
    logic                        rd_ack;
    logic [31:0]                 readdata;
  } unit_state_t;

  unit_state_t s_r;
  unit_state_t s_nxt;

  function automatic logic [31:0] rev32(input logic [31:0] d);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      r[i] = d[31-i];
    end
    return r;
  endfunction

  function automatic logic [5:0] generator_divisor_bits(input logic [1:0] sel);
    case (sel)
      crc_calc_pkg::WSEL_16: generator_divisor_bits = 6'h10;
      crc_calc_pkg::WSEL_8:  generator_divisor_bits = 6'h08;
      crc_calc_pkg::WSEL_7:  generator_divisor_bits = 6'h07;
      default:               generator_divisor_bits = 6'h20;
    endcase
  endfunction

  function automatic logic [5:0] data_bits(input logic [1:0] dsz);
    case (dsz)
      crc_calc_pkg::DSZ_16: data_bits = 6'h10;
      crc_calc_pkg::DSZ_8:  data_bits = 6'h08;
      default:              data_bits = 6'h20;
    endcase
  endfunction

  // low-bit mask for an n-bit quantity, n from 1 to 32
  function automatic logic [31:0] low_mask(input logic [5:0] n);
    return crc_calc_pkg::ALL_ONES >> (6'h20 - n);
  endfunction

  // input reordering never crosses the written size
  function automatic logic [31:0] reorder_in(input logic [31:0] d,
                                             input logic [1:0]  mode,
                                             input logic [5:0]  n);
    logic [31:0] byte_rev;
    logic [31:0] half_rev;
    logic [31:0] r;
    logic [31:0] rv;
    rv       = rev32(d);
    byte_rev = {rv[7:0], rv[15:8], rv[23:16], rv[31:24]};
    half_rev = {rv[15:0], rv[31:16]};
    case (mode)
      crc_calc_pkg::RIN_BYTE: r = byte_rev;
      crc_calc_pkg::RIN_HALF: r = (n == 6'h08) ? byte_rev : half_rev;
      crc_calc_pkg::RIN_WORD: r = rv >> (6'h20 - n);
      default:                r = d;
    endcase
    return r & low_mask(n);
  endfunction

  // fifo between bus writes and the bit-serial engine
  logic          fifo_in_valid;
  logic          fifo_in_ready;
  logic [FW-1:0] fifo_in_data;
  logic          fifo_out_valid;
  logic          fifo_out_ready;
  logic [FW-1:0] fifo_out_data;

  // bus decode
  logic        hit_data;
  logic        data_wr;
  logic        busy;
  logic [1:0]  wr_size;
  logic [5:0]  pw;
  logic [5:0]  dw;
  logic [31:0] step_val;

  assign hit_data = (AVS_ADDRESS == crc_calc_pkg::OFS_DATA);
  assign data_wr  = AVS_WRITE && hit_data;
  assign busy     = fifo_out_valid || (s_r.state == crc_calc_pkg::ST_RUN);

  always_comb begin
    if (AVS_BYTEENABLE == crc_calc_pkg::BE_BYTE) begin
      wr_size = crc_calc_pkg::DSZ_8;
    end else if (AVS_BYTEENABLE == crc_calc_pkg::BE_HALF) begin
      wr_size = crc_calc_pkg::DSZ_16;
    end else begin
      wr_size = crc_calc_pkg::DSZ_32;
    end
  end

  assign fifo_in_valid  = data_wr;
  assign fifo_in_data   = {wr_size, AVS_WRITEDATA};
  assign fifo_out_ready = (s_r.state == crc_calc_pkg::ST_IDLE);

  // data writes stall only on a full queue; everything else waits for idle
  always_comb begin
    if (data_wr) begin
      AVS_WAITREQUEST = !fifo_in_ready;
    end else if (AVS_WRITE) begin
      AVS_WAITREQUEST = busy;
    end else if (AVS_READ) begin
      AVS_WAITREQUEST = !s_r.rd_ack;
    end else begin
      AVS_WAITREQUEST = 1'b0;
    end
  end

  assign AVS_READDATA = s_r.readdata;

  assign pw       = generator_divisor_bits(s_r.divisor_width_sel);
  assign dw       = data_bits(fifo_out_data[FW-1:FW-2]);
  assign step_val = s_r.work[31]
                  ? ((s_r.work << 1) ^ (s_r.generator_coefficients << (6'h20 - pw)))
                  : (s_r.work << 1);

  crc_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (MCLK),
    .rst       (RESET),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    s_nxt        = s_r;
    s_nxt.rd_ack = 1'b0;

    // engine: both operands left-aligned so any width pairing divides correctly
    case (s_r.state)
      crc_calc_pkg::ST_IDLE: begin
        if (fifo_out_valid) begin
          s_nxt.work  = (s_r.checksum_data << (6'h20 - pw))
                      ^ (reorder_in(fifo_out_data[31:0], s_r.input_bit_reverse, dw)
                         << (6'h20 - dw));
          s_nxt.steps = dw;
          s_nxt.state = crc_calc_pkg::ST_RUN;
        end
      end
      crc_calc_pkg::ST_RUN: begin
        s_nxt.work  = step_val;
        s_nxt.steps = s_r.steps - 6'h01;
        if (s_r.steps == 6'h01) begin
          s_nxt.checksum_data = (step_val >> (6'h20 - pw)) & low_mask(pw);
          s_nxt.state         = crc_calc_pkg::ST_IDLE;
        end
      end
      default: begin
        s_nxt.state = crc_calc_pkg::ST_IDLE;
      end
    endcase

    // register writes, taken only while the engine is idle
    if (AVS_WRITE && !busy) begin
      case (AVS_ADDRESS)
        crc_calc_pkg::OFS_SEED: begin
          s_nxt.checksum_seed = AVS_WRITEDATA;
        end
        crc_calc_pkg::OFS_GEN: begin
          s_nxt.generator_coefficients = AVS_WRITEDATA;
        end
        crc_calc_pkg::OFS_CONTROL: begin
          s_nxt.divisor_width_sel  =
            AVS_WRITEDATA[crc_calc_pkg::CTL_WSEL_LO +: 2];
          s_nxt.input_bit_reverse  =
            AVS_WRITEDATA[crc_calc_pkg::CTL_RIN_LO +: 2];
          s_nxt.output_bit_reverse =
            AVS_WRITEDATA[crc_calc_pkg::CTL_ROUT_BIT];
          if (AVS_WRITEDATA[crc_calc_pkg::CTL_RESET_BIT]) begin
            // seed loads at once, so the reset bit never stays set
            s_nxt.checksum_data = s_r.checksum_seed
                                & low_mask(generator_divisor_bits(
                                    AVS_WRITEDATA[crc_calc_pkg::CTL_WSEL_LO +: 2]));
          end
        end
        default: begin
        end
      endcase
    end

    // reads answer one cycle after the bus finds the engine idle
    if (AVS_READ && !s_r.rd_ack && !busy) begin
      s_nxt.rd_ack = 1'b1;
      case (AVS_ADDRESS)
        crc_calc_pkg::OFS_DATA: begin
          s_nxt.readdata = s_r.output_bit_reverse
                         ? rev32(s_r.checksum_data) : s_r.checksum_data;
        end
        crc_calc_pkg::OFS_SEED: begin
          s_nxt.readdata = s_r.checksum_seed;
        end
        crc_calc_pkg::OFS_GEN: begin
          s_nxt.readdata = s_r.generator_coefficients;
        end
        crc_calc_pkg::OFS_CONTROL: begin
          s_nxt.readdata = '0;
          s_nxt.readdata[crc_calc_pkg::CTL_WSEL_LO +: 2] = s_r.divisor_width_sel;
          s_nxt.readdata[crc_calc_pkg::CTL_RIN_LO +: 2]  = s_r.input_bit_reverse;
          s_nxt.readdata[crc_calc_pkg::CTL_ROUT_BIT]     = s_r.output_bit_reverse;
        end
        default: begin
          s_nxt.readdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      s_r.checksum_data          <= crc_calc_pkg::RST_SEED;
      s_r.checksum_seed          <= crc_calc_pkg::RST_SEED;
      s_r.generator_coefficients <= crc_calc_pkg::RST_GEN;
      s_r.divisor_width_sel      <= 2'h0;
      s_r.input_bit_reverse      <= 2'h0;
      s_r.output_bit_reverse     <= 1'b0;
      s_r.state                  <= crc_calc_pkg::ST_IDLE;
      s_r.steps                  <= 6'h00;
      s_r.work                   <= 32'h0000_0000;
      s_r.rd_ack                 <= 1'b0;
      s_r.readdata               <= 32'h0000_0000;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

`default_nettype wire

//--- dv/crc_calc_unit_assertions.sv
`default_nettype none
module crc_calc_unit_assertions #(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic        MCLK,
  input wire logic        RESET,
  // avalon-mm slave
  input wire logic [3:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST
);
  timeunit 1ns;
  timeprecision 1ps;
  // cycles without any request; long enough means queue and engine are drained
  logic [8:0] idle_cnt;
  logic       idle_long;
  assign idle_long = idle_cnt >= 9'(40 * (FIFO_DEPTH + 1));
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET)
      idle_cnt <= 9'h000;
    else if (AVS_READ || AVS_WRITE)
      idle_cnt <= 9'h000;
    else if (idle_cnt != 9'h1FF)
      idle_cnt <= idle_cnt + 9'h001;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  sequence s_one_wait;
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
  endsequence
  sequence s_rd_answer;
    AVS_READ && !AVS_WAITREQUEST;
  endsequence
  a_rd_first_wait: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST)
    else $error("read answered in its first cycle");
  a_rd_after_idle: assert property (AVS_READ && idle_long |-> s_one_wait)
    else $error("idle read not answered after one wait cycle");
  a_wait_bounded: assert property (AVS_WAITREQUEST |-> ##[1:200] !AVS_WAITREQUEST)
    else $error("bus held too long");
  a_idle_no_wait: assert property (!AVS_READ && !AVS_WRITE |-> !AVS_WAITREQUEST)
    else $error("wait raised without request");
  a_wr_after_idle: assert property (AVS_WRITE && idle_long |-> !AVS_WAITREQUEST)
    else $error("idle write was held");
  a_rdata_holds: assert property ($changed(AVS_READDATA) |-> s_rd_answer)
    else $error("read data moved outside a read answer");
  a_rdata_reset: assert property ($fell(RESET) |-> AVS_READDATA == 32'h0000_0000)
    else $error("read data not cleared by reset");
  a_unmapped_zero: assert property (s_rd_answer ##0 AVS_ADDRESS[1:0] != 2'h0
    |-> AVS_READDATA == 32'h0000_0000) else $error("unmapped read not zero");
  a_ctl_bit_clear: assert property (s_rd_answer ##0
    AVS_ADDRESS == crc_calc_pkg::OFS_CONTROL |-> !AVS_READDATA[crc_calc_pkg::CTL_RESET_BIT])
    else $error("control reset bit reads one");
endmodule

bind crc_calc_unit crc_calc_unit_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (
  .MCLK(MCLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
`default_nettype wire

//--- dv/crc_bus_host.sv
`default_nettype none
module crc_bus_host (
  // bus clock
  input  wire logic        clk,
  // request side
  output var  logic [3:0]  address,
  output var  logic        read,
  output var  logic        write,
  output var  logic [31:0] writedata,
  output var  logic [3:0]  byteenable,
  // answer side
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  int stalls = 0;
  initial begin
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'hF;
  end
  // one transfer; request held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic rw, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= rw;
    read <= !rw;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      stalls++;
      @(posedge clk);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    writedata <= ~d;
    address <= ~a;
  endtask
endmodule
`default_nettype wire

//--- dv/test_crc_calc_unit.sv
`default_nettype none
module test_crc_calc_unit;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0]  w;
    logic [1:0]  ri;
    logic        ro;
    logic [3:0]  be;
    logic [31:0] gen;
    logic [31:0] seed;
  } cfg_t;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  address, byteenable;
  logic        read, write, waitrequest;
  logic [31:0] writedata, readdata, q, exp_reg;
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;
  cfg_t        tbl [5] = '{'{2'h2, 2'h0, 1'b0, 4'h1, 32'h0000_00CB, 32'h0000_00FF},
                           '{2'h0, 2'h1, 1'b0, 4'hF, 32'h04C1_1DB7, 32'hFFFF_FFFF},
                           '{2'h1, 2'h2, 1'b1, 4'h3, 32'h0000_1021, 32'h0000_FFFF},
                           '{2'h3, 2'h3, 1'b0, 4'h1, 32'h0000_0009, 32'h0000_007F},
                           '{2'h0, 2'h3, 1'b1, 4'h3, 32'h1EDC_6F41, 32'h0000_0000}};
  logic [31:0] din [3] = '{32'h0000_00C1, 32'hA53C_960F, 32'h1234_5678};

  always #25 mclk = ~mclk;

  crc_calc_unit i_dut (.MCLK(mclk), .RESET(reset), .AVS_ADDRESS(address), .AVS_READ(read),
    .AVS_WRITE(write), .AVS_WRITEDATA(writedata), .AVS_BYTEENABLE(byteenable),
    .AVS_READDATA(readdata), .AVS_WAITREQUEST(waitrequest));
  crc_bus_host i_host (.clk(mclk), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    i_host.xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
    chk(what, q, exp);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    i_host.xfer(1'b1, a, d, be, q);
  endtask
  function automatic int width(input logic [1:0] w);
    return (w == crc_calc_pkg::WSEL_32) ? 32 : (w == crc_calc_pkg::WSEL_16) ? 16 :
           (w == crc_calc_pkg::WSEL_8) ? 8 : 7;
  endfunction
  function automatic logic [31:0] ctl(input cfg_t t);
    return (32'(t.w) << crc_calc_pkg::CTL_WSEL_LO) | (32'(t.ri) << crc_calc_pkg::CTL_RIN_LO) |
           (32'(t.ro) << crc_calc_pkg::CTL_ROUT_BIT);
  endfunction
  function automatic logic [31:0] outv(input logic [31:0] x, input cfg_t t);
    logic [31:0] y;
    y = {<<{x}};
    return t.ro ? y : x;
  endfunction
  function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] d, input cfg_t t);
    logic [31:0] x;
    logic [31:0] r;
    int p, n, k;
    p = width(t.w);
    n = (t.be == crc_calc_pkg::BE_BYTE) ? 8 : (t.be == crc_calc_pkg::BE_HALF) ? 16 : 32;
    k = (t.ri == crc_calc_pkg::RIN_BYTE) ? 8 : (t.ri == crc_calc_pkg::RIN_HALF) ? 16 : n;
    r = d;
    for (int i = 0; i < n; i++)
      if (t.ri != crc_calc_pkg::RIN_NONE) r[i] = d[(i / k) * k + k - 1 - i % k];
    x = (c << (32 - p)) ^ (r << (32 - n));
    for (int i = 0; i < n; i++)
      x = x[31] ? (x << 1) ^ (t.gen << (32 - p)) : x << 1;
    return x >> (32 - p);
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("Error timeout expected done seen hung");
      print_verdict();
    end
  end

  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    repeat (210) @(posedge mclk);
    rd(crc_calc_pkg::OFS_CONTROL, crc_calc_pkg::RST_CONTROL, "control");
    rd(crc_calc_pkg::OFS_SEED, crc_calc_pkg::RST_SEED, "seed");
    rd(crc_calc_pkg::OFS_GEN, crc_calc_pkg::RST_GEN, "generator");
    rd(crc_calc_pkg::OFS_DATA, crc_calc_pkg::ALL_ONES, "data");
    wr(4'h6, 32'h1234_5678, 4'hF);
    rd(4'h6, 32'h0000_0000, "unmapped");
    $display("test reset_values done");
    foreach (tbl[e]) begin
      wr(crc_calc_pkg::OFS_GEN, tbl[e].gen, 4'hF);
      wr(crc_calc_pkg::OFS_SEED, tbl[e].seed, 4'hF);
      wr(crc_calc_pkg::OFS_CONTROL, ctl(tbl[e]) | 32'h0000_0001, 4'hF);
      exp_reg = (tbl[e].seed << (32 - width(tbl[e].w))) >> (32 - width(tbl[e].w));
      rd(crc_calc_pkg::OFS_DATA, outv(exp_reg, tbl[e]), "seeded data");
      rd(crc_calc_pkg::OFS_CONTROL, ctl(tbl[e]), "control");
      rd(crc_calc_pkg::OFS_GEN, tbl[e].gen, "generator");
      foreach (din[i]) begin
        wr(crc_calc_pkg::OFS_DATA, din[i], tbl[e].be);
        exp_reg = fold(exp_reg, din[i], tbl[e]);
        if (e == 0 && i == 0)
          chk("worked example", exp_reg, 32'h0000_004C);
        if (i == 0)
          rd(crc_calc_pkg::OFS_DATA, outv(exp_reg, tbl[e]), "first word");
      end
      rd(crc_calc_pkg::OFS_DATA, outv(exp_reg, tbl[e]), "running sum");
    end
    $display("test modes done");
    i_host.stalls = 0;
    repeat (210) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      wr(crc_calc_pkg::OFS_DATA, din[i % 3], tbl[4].be);
      exp_reg = fold(exp_reg, din[i % 3], tbl[4]);
    end
    chk("stall", (i_host.stalls > 0) ? 32'h0000_0001 : 32'h0000_0000, 32'h0000_0001);
    rd(crc_calc_pkg::OFS_DATA, outv(exp_reg, tbl[4]), "queued sum");
    $display("test queue_full done");
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(crc_calc_pkg::OFS_CONTROL, crc_calc_pkg::RST_CONTROL, "control again");
    rd(crc_calc_pkg::OFS_GEN, crc_calc_pkg::RST_GEN, "generator again");
    rd(crc_calc_pkg::OFS_SEED, crc_calc_pkg::RST_SEED, "seed again");
    rd(crc_calc_pkg::OFS_DATA, crc_calc_pkg::ALL_ONES, "data again");
    $display("test second_reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
